// *** core/alu_core.sv ***
// sixteen-bit arithmetic logic unit with multiplier and divide step hardware
`timescale 1ns/1ns
// Overview of operation
// - datapath for arithmetic and logic is sixteen bits wide
// - supports add, subtract, shifts and bitwise logic
// - arithmetic operands and results are two's complement unless stated
// - updates carry, zero, negative, overflow and nibble carry per operation
// - subtract uses carry as inverted borrow, nibble carry as inverted nibble borrow
// - each operation except divide runs at byte or word width per instruction mode; divide is always word width
// - operands come from working registers or memory, decoder selects
// - result goes to working registers or memory, decoder indicates which
// - dedicated multiplier with two seventeen-bit operands
// - word products in ss, uu, us and su sign modes
// - word times unsigned five-bit literal, signed or unsigned word
// - unsigned byte by unsigned byte multiply
// - hardware division support for sixteen-bit divisor
module alu_core
    import alu_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              start,
    input  wire alu_cmd_t          cmd,
    input  wire logic [DATA_W-1:0] wreg_a,
    input  wire logic [DATA_W-1:0] wreg_b,
    input  wire logic [DATA_W-1:0] mem_a,
    input  wire logic [DATA_W-1:0] mem_b,
    input  wire logic [DATA_W-1:0] div_hi,
    output logic      [DATA_W-1:0] result,
    output logic      [DATA_W-1:0] result_hi,
    output logic                   wreg_we,
    output logic                   mem_we,
    output logic                   done,
    output logic                   busy,
    output flags_t                 status_flags_register
);
    typedef enum logic [1:0] { ST_IDLE, ST_DIV, ST_FIN } state_t;

    state_t            state;
    logic [DATA_W-1:0] op_a;
    logic [DATA_W-1:0] op_b;
    logic [PROD_W-1:0] product;
    logic [DATA_W-1:0] next_res;
    flags_t            next_flags;
    logic              c_word;
    logic              c_byte;
    logic              nib_carry;
    logic              sub_op;
    logic              arith_op;
    logic [DATA_W:0]   sum;
    logic [NIB_W:0]    nib_sum;
    logic [BYTE_W:0]   byte_sum;
    logic [DATA_W-1:0] b_eff;
    logic              cin;
    // divider registers
    logic [DATA_W:0]   rem;
    logic [DATA_W-1:0] quo;
    logic [DATA_W-1:0] divisor;
    logic [4:0]        step;
    logic              neg_q;
    logic              neg_r;
    dst_sel_t          dst_hold;
    logic [DATA_W:0]   trial;

    // ======================================================================
    // operand selection
    assign op_a = (cmd.src_a == SRC_MEM) ? mem_a : wreg_a;
    assign op_b = (cmd.src_b == SRC_MEM) ? mem_b : wreg_b;

    alu_multiplier u_mul (
        .a       (op_a),
        .b       (op_b),
        .literal (cmd.literal),
        .mode    (cmd.mmode),
        .product (product)
    );

    // ======================================================================
    // adder and logic
    always_comb begin
        sub_op   = (cmd.op == OP_SUB) || (cmd.op == OP_SUBB);
        arith_op = sub_op || (cmd.op == OP_ADD) || (cmd.op == OP_ADDC);
        b_eff    = sub_op ? ~op_b : op_b;
        // carry as inverted borrow
        cin      = (cmd.op == OP_SUB) ? 1'b1 :
                   ((cmd.op == OP_ADDC) || (cmd.op == OP_SUBB)) ? status_flags_register.c
                                                                : 1'b0;
        sum      = {1'b0, op_a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, cin};
        nib_sum  = {1'b0, op_a[NIB_W-1:0]} + {1'b0, b_eff[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
        byte_sum = {1'b0, op_a[BYTE_W-1:0]} + {1'b0, b_eff[BYTE_W-1:0]}
                   + {{BYTE_W{1'b0}}, cin};
        nib_carry = nib_sum[NIB_W];
        c_word   = sum[DATA_W];
        c_byte   = byte_sum[BYTE_W];
        next_res = WORD_ZERO;
        case (cmd.op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: next_res = sum[DATA_W-1:0];
            OP_AND: next_res = op_a & op_b;
            OP_IOR: next_res = op_a | op_b;
            OP_XOR: next_res = op_a ^ op_b;
            OP_SHL: next_res = op_a << 1;
            OP_LSR: next_res = cmd.byte_mode ? {8'h00, 1'b0, op_a[BYTE_W-1:1]}
                                             : {1'b0, op_a[DATA_W-1:1]};
            OP_ASR: next_res = cmd.byte_mode ? {8'h00, op_a[BYTE_W-1], op_a[BYTE_W-1:1]}
                                             : {op_a[DATA_W-1], op_a[DATA_W-1:1]};
            OP_MUL: next_res = product[DATA_W-1:0];
            OP_MOV: next_res = op_a;
            default: next_res = WORD_ZERO;
        endcase
        if (cmd.byte_mode) begin
            next_res = {8'h00, next_res[BYTE_W-1:0]};
        end
    end

    // flag computation, undefined flags held
    always_comb begin
        next_flags = status_flags_register;
        if (cmd.op != OP_MUL && cmd.op != OP_DIVU && cmd.op != OP_DIVS) begin
            next_flags.z = cmd.byte_mode ? (next_res[BYTE_W-1:0] == 8'h00)
                                         : (next_res == WORD_ZERO);
            next_flags.n = cmd.byte_mode ? next_res[BYTE_W-1] : next_res[DATA_W-1];
        end
        if (arith_op) begin
            next_flags.c  = cmd.byte_mode ? c_byte : c_word;
            next_flags.nibble_carry_flag = nib_carry;
            next_flags.ov = cmd.byte_mode
                ? ((op_a[BYTE_W-1] == b_eff[BYTE_W-1]) && (next_res[BYTE_W-1] != op_a[BYTE_W-1]))
                : ((op_a[DATA_W-1] == b_eff[DATA_W-1]) && (next_res[DATA_W-1] != op_a[DATA_W-1]));
        end
        if (cmd.op == OP_SHL) begin
            next_flags.c = cmd.byte_mode ? op_a[BYTE_W-1] : op_a[DATA_W-1];
        end
        if (cmd.op == OP_LSR || cmd.op == OP_ASR) begin
            next_flags.c = op_a[0];
        end
    end

    // ======================================================================
    // divider: restoring, one quotient bit per cycle
    assign trial = {rem[DATA_W-1:0], quo[DATA_W-1]} - {1'b0, divisor};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            rem      <= '0;
            quo      <= WORD_ZERO;
            divisor  <= WORD_ZERO;
            step     <= 5'h00;
            neg_q    <= 1'b0;
            neg_r    <= 1'b0;
            dst_hold <= DST_WREG;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start && (cmd.op == OP_DIVU || cmd.op == OP_DIVS)) begin
                        state    <= ST_DIV;
                        step     <= 5'h00;
                        rem      <= '0;
                        dst_hold <= cmd.dst;
                        if (cmd.op == OP_DIVS) begin
                            quo     <= op_a[DATA_W-1] ? -op_a : op_a;
                            divisor <= op_b[DATA_W-1] ? -op_b : op_b;
                            neg_q   <= op_a[DATA_W-1] ^ op_b[DATA_W-1];
                            neg_r   <= op_a[DATA_W-1];
                        end else begin
                            quo     <= op_a;
                            divisor <= op_b;
                            neg_q   <= 1'b0;
                            neg_r   <= 1'b0;
                        end
                    end
                end
                ST_DIV: begin
                    if (!trial[DATA_W]) begin
                        rem <= trial;
                        quo <= {quo[DATA_W-2:0], 1'b1};
                    end else begin
                        rem <= {rem[DATA_W-1:0], quo[DATA_W-1]};
                        quo <= {quo[DATA_W-2:0], 1'b0};
                    end
                    step <= step + 5'h01;
                    if (step == 5'(DIV_STEPS - 1)) begin
                        state <= ST_FIN;
                    end
                end
                ST_FIN: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result                <= WORD_ZERO;
            result_hi             <= WORD_ZERO;
            wreg_we               <= 1'b0;
            mem_we                <= 1'b0;
            done                  <= 1'b0;
            busy                  <= 1'b0;
            status_flags_register <= FLAGS_RST;
        end else begin
            wreg_we <= 1'b0;
            mem_we  <= 1'b0;
            done    <= 1'b0;
            if (state == ST_IDLE && start && cmd.op != OP_DIVU && cmd.op != OP_DIVS) begin
                result    <= next_res;
                result_hi <= (cmd.op == OP_MUL) ? product[PROD_W-1:DATA_W] : WORD_ZERO;
                wreg_we   <= (cmd.dst == DST_WREG);
                mem_we    <= (cmd.dst == DST_MEM);
                done      <= 1'b1;
                status_flags_register <= next_flags;
            end else if (state == ST_IDLE && start) begin
                busy <= 1'b1;
            end else if (state == ST_FIN) begin
                result    <= neg_q ? -quo : quo;
                result_hi <= neg_r ? -rem[DATA_W-1:0] : rem[DATA_W-1:0];
                wreg_we   <= (dst_hold == DST_WREG);
                mem_we    <= (dst_hold == DST_MEM);
                done      <= 1'b1;
                busy      <= 1'b0;
            end
        end
    end

    // ======================================================================
    // checks
    chk_write_one_dst: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(wreg_we && mem_we)) else $error("both destinations written");
    chk_done_has_we: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done |-> (wreg_we || mem_we)) else $error("done without write");
    chk_byte_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && state == ST_IDLE && cmd.byte_mode && cmd.op != OP_DIVU && cmd.op != OP_DIVS)
        |=> result[DATA_W-1:BYTE_W] == 8'h00) else $error("byte result upper set");
    chk_zero_flag_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && state == ST_IDLE && !cmd.byte_mode && cmd.op == OP_AND)
        |=> status_flags_register.z == (result == WORD_ZERO)) else $error("zero flag wrong");
    chk_flags_kept_mul: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && state == ST_IDLE && cmd.op == OP_MUL)
        |=> $stable(status_flags_register)) else $error("multiply changed flags");
    chk_sub_no_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && state == ST_IDLE && cmd.op == OP_SUB && !cmd.byte_mode && op_a >= op_b)
        |=> status_flags_register.c) else $error("borrow wrong on subtract");
    chk_mul_uu_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && state == ST_IDLE && cmd.op == OP_MUL && cmd.mmode == MUL_UU && !cmd.byte_mode)
        |=> {result_hi, result} == 32'($past(op_a)) * 32'($past(op_b)))
        else $error("uu product");
    chk_div_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && state == ST_IDLE && cmd.op == OP_DIVU) |-> ##18 done)
        else $error("divide not done in time");
    cov_div: cover property (@(posedge ref_clk) state == ST_FIN);
    cov_byte_add: cover property (@(posedge ref_clk) start && cmd.byte_mode && cmd.op == OP_ADD);
    cov_mul_bb: cover property (@(posedge ref_clk) start && cmd.op == OP_MUL && cmd.mmode == MUL_BB);
endmodule

// *** core/alu_pkg.sv ***
// shared types and constants for the arithmetic unit
package alu_pkg;
    localparam int DATA_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int MUL_W    = 17;
    localparam int LIT_W    = 5;
    localparam int NIB_W    = 4;
    localparam int PROD_W   = 32;
    localparam int DIV_STEPS = 16;

    typedef enum logic [3:0] {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
        OP_SHL, OP_LSR, OP_ASR, OP_MUL, OP_DIVU, OP_DIVS, OP_MOV
    } alu_op_t;

    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_SL, MUL_UL, MUL_US, MUL_SU, MUL_BB
    } mul_mode_t;

    typedef enum logic { SRC_WREG, SRC_MEM } src_sel_t;
    typedef enum logic { DST_WREG, DST_MEM } dst_sel_t;

    typedef struct packed {
        logic c;
        logic z;
        logic n;
        logic ov;
        logic nibble_carry_flag;
    } flags_t;

    typedef struct packed {
        alu_op_t   op;
        mul_mode_t mmode;
        logic      byte_mode;
        src_sel_t  src_a;
        src_sel_t  src_b;
        dst_sel_t  dst;
        logic [LIT_W-1:0] literal;
    } alu_cmd_t;

    localparam flags_t FLAGS_RST = '{c: 1'b0, z: 1'b0, n: 1'b0, ov: 1'b0,
                                     nibble_carry_flag: 1'b0};
    localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage

// *** core/alu_multiplier.sv ***
// 17x17 signed multiplier with operand sign extension per mode
`timescale 1ns/1ns
module alu_multiplier
    import alu_pkg::*;
(
    input  wire logic [DATA_W-1:0] a,
    input  wire logic [DATA_W-1:0] b,
    input  wire logic [LIT_W-1:0]  literal,
    input  wire mul_mode_t         mode,
    output logic      [PROD_W-1:0] product
);
    logic signed [MUL_W-1:0]   op_a;
    logic signed [MUL_W-1:0]   op_b;
    logic signed [2*MUL_W-1:0] full;

    always_comb begin
        op_a = {1'b0, a};
        op_b = {1'b0, b};
        case (mode)
            MUL_SS: begin
                op_a = {a[DATA_W-1], a};
                op_b = {b[DATA_W-1], b};
            end
            MUL_SL: begin
                op_a = {a[DATA_W-1], a};
                op_b = {{(MUL_W-LIT_W){1'b0}}, literal};
            end
            MUL_UL: op_b = {{(MUL_W-LIT_W){1'b0}}, literal};
            MUL_US: op_b = {b[DATA_W-1], b};
            MUL_SU: op_a = {a[DATA_W-1], a};
            MUL_BB: begin
                op_a = {{(MUL_W-BYTE_W){1'b0}}, a[BYTE_W-1:0]};
                op_b = {{(MUL_W-BYTE_W){1'b0}}, b[BYTE_W-1:0]};
            end
            default: ;
        endcase
        full    = op_a * op_b;
        product = full[PROD_W-1:0];
    end
endmodule

// *** dv/operand_store.sv ***
// partner model: working registers and data memory around the unit
`timescale 1ns/1ns
module operand_store
    import alu_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              load,
    input  wire logic [63:0]       set_ops,
    input  wire logic [DATA_W-1:0] result,
    input  wire logic              wreg_we,
    input  wire logic              mem_we,
    output logic      [DATA_W-1:0] wreg_a,
    output logic      [DATA_W-1:0] wreg_b,
    output logic      [DATA_W-1:0] mem_a,
    output logic      [DATA_W-1:0] mem_b,
    output logic      [DATA_W-1:0] wreg_dest,
    output logic      [DATA_W-1:0] mem_dest
);
    // both sources always offered, decoder picks one
    always_ff @(posedge ref_clk) begin
        if (load) begin
            {wreg_a, wreg_b, mem_a, mem_b} <= set_ops;
        end
    end
    // sink follows the destination strobe
    always_ff @(posedge ref_clk) begin
        if (wreg_we) begin
            wreg_dest <= result;
        end
        if (mem_we) begin
            mem_dest <= result;
        end
    end
endmodule

// *** dv/tb_alu_core.sv ***
// self-checking bench for the arithmetic unit
`timescale 1ns/1ns
module tb_alu_core
    import alu_pkg::*;
;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] LOB = 32'h0000_00FF;
    logic ref_clk = 1'b0, rst_n = 1'b0, start = 1'b0, load = 1'b0;
    alu_cmd_t cmd = '0;
    logic [63:0] set_ops = '0;
    logic [DATA_W-1:0] wreg_a, wreg_b, mem_a, mem_b, result, result_hi, wreg_dest, mem_dest;
    logic wreg_we, mem_we, done, busy;
    flags_t status_flags_register;
    int failures = 0;
    int total_checks = 0;

    alu_core alu_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .cmd(cmd),
        .wreg_a(wreg_a), .wreg_b(wreg_b), .mem_a(mem_a), .mem_b(mem_b), .div_hi(16'h0000),
        .result(result), .result_hi(result_hi), .wreg_we(wreg_we), .mem_we(mem_we),
        .done(done), .busy(busy), .status_flags_register(status_flags_register));
    operand_store operand_store_inst (.ref_clk(ref_clk), .load(load), .set_ops(set_ops),
        .result(result), .wreg_we(wreg_we), .mem_we(mem_we), .wreg_a(wreg_a),
        .wreg_b(wreg_b), .mem_a(mem_a), .mem_b(mem_b), .wreg_dest(wreg_dest),
        .mem_dest(mem_dest));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ==========================================
    // helpers
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic alu_cmd_t mk(alu_op_t op, int bm, logic [2:0] sel, mul_mode_t mm,
                                    int lit);
        mk = '{op: op, mmode: mm, byte_mode: bm[0], src_a: src_sel_t'(sel[2]),
               src_b: src_sel_t'(sel[1]), dst: dst_sel_t'(sel[0]), literal: lit[LIT_W-1:0]};
    endfunction

    // one operation; a second start is offered mid divide and must be ignored
    task automatic run(string name, alu_cmd_t c, logic [63:0] ops, logic [31:0] exp,
                       logic [31:0] mask, logic [4:0] ef, logic [4:0] fm);
        int n;
        int lat;
        lat = (c.op == OP_DIVU || c.op == OP_DIVS) ? 18 : 1;
        @(posedge ref_clk);
        load <= 1'b1;
        set_ops <= ops;
        @(posedge ref_clk);
        load <= 1'b0;
        start <= 1'b1;
        cmd <= c;
        n = 0;
        do begin
            @(posedge ref_clk);
            start <= (n + 1 == 5);
            n++;
            #1;
            if (n == 1 && lat > 1) begin
                check({name, " busy"}, 32'h1, 32'(busy));
            end
        end while (done !== 1'b1 && n < 40);
        check({name, " latency"}, 32'(lat), 32'(n));
        check({name, " value"}, exp & mask, {result_hi, result} & mask);
        check({name, " flags"}, 32'(ef & fm), 32'(status_flags_register & fm));
        check({name, " strobes"}, {30'h0, c.dst == DST_MEM, c.dst == DST_WREG},
              {30'h0, mem_we, wreg_we});
        @(posedge ref_clk);
        #1;
        check({name, " sink"}, 32'(result), 32'(c.dst == DST_MEM ? mem_dest : wreg_dest));
        check({name, " pulse"}, 32'h0, {busy, done, mem_we, wreg_we});
        $display("test %s done", name);
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check("reset", 32'h0, {result, 10'h0, done, status_flags_register});
        run("add_ov", mk(OP_ADD, 0, 3'b000, MUL_SS, 0), 64'h7FFF_0001_0000_0000,
            32'h8000, ALL, 5'b00111, 5'h1F);
        run("and_mem", mk(OP_AND, 0, 3'b011, MUL_SS, 0), 64'h8000_FFFF_0000_00FF,
            32'h0, ALL, 5'b01011, 5'h1F);
        run("sub_eq", mk(OP_SUB, 0, 3'b100, MUL_SS, 0), 64'h0000_0005_0005_0000,
            32'h0, ALL, 5'b11001, 5'h1F);
        run("sub_brw", mk(OP_SUB, 0, 3'b000, MUL_SS, 0), 64'h0000_0001_0000_0000,
            32'hFFFF, ALL, 5'b00100, 5'h1F);
        run("sub_ov", mk(OP_SUB, 0, 3'b000, MUL_SS, 0), 64'h8000_0001_0000_0000,
            32'h7FFF, ALL, 5'b10010, 5'h1F);
        run("add_byte", mk(OP_ADD, 1, 3'b000, MUL_SS, 0), 64'h12FF_3401_0000_0000,
            32'h0, LOB, 5'b11001, 5'h1F);
        run("sub_byte", mk(OP_SUB, 1, 3'b000, MUL_SS, 0), 64'hAA80_5501_0000_0000,
            32'h7F, LOB, 5'b10010, 5'h1F);
        run("addc", mk(OP_ADDC, 0, 3'b000, MUL_SS, 0), 64'hFFFF_0000_0000_0000,
            32'h0, ALL, 5'b10001, 5'b10011);
        run("subb", mk(OP_SUBB, 0, 3'b000, MUL_SS, 0), 64'h0003_0001_0000_0000,
            32'h2, ALL, 5'b10000, 5'b10000);
        run("mul_ss", mk(OP_MUL, 0, 3'b000, MUL_SS, 0), 64'hFFFF_0002_0000_0000,
            32'hFFFF_FFFE, ALL, 5'b10000, 5'b10000);
        run("mul_uu", mk(OP_MUL, 0, 3'b000, MUL_UU, 0), 64'h8000_0002_0000_0000,
            32'h0001_0000, ALL, 5'b10000, 5'b10000);
        run("mul_us", mk(OP_MUL, 0, 3'b000, MUL_US, 0), 64'h8000_FFFF_0000_0000,
            32'hFFFF_8000, ALL, 5'b10000, 5'b10000);
        run("mul_su", mk(OP_MUL, 0, 3'b000, MUL_SU, 0), 64'h8000_0002_0000_0000,
            32'hFFFF_0000, ALL, 5'b10000, 5'b10000);
        run("mul_sl", mk(OP_MUL, 0, 3'b000, MUL_SL, 31), 64'hFFFF_0000_0000_0000,
            32'hFFFF_FFE1, ALL, 5'b10000, 5'b10000);
        run("mul_ul", mk(OP_MUL, 0, 3'b000, MUL_UL, 31), 64'hFFFF_0000_0000_0000,
            32'h001E_FFE1, ALL, 5'b10000, 5'b10000);
        run("mul_bb", mk(OP_MUL, 0, 3'b000, MUL_BB, 0), 64'h12FF_34FF_0000_0000,
            32'h0000_FE01, ALL, 5'b10000, 5'b10000);
        run("divu", mk(OP_DIVU, 0, 3'b001, MUL_SS, 0), 64'h03E8_0007_0000_0000,
            32'h0006_008E, ALL, 5'b10000, 5'b10000);
        run("divs", mk(OP_DIVS, 0, 3'b000, MUL_SS, 0), 64'hFC18_0007_0000_0000,
            32'hFFFA_FF72, ALL, 5'b10000, 5'b10000);
        run("add_after", mk(OP_ADD, 0, 3'b010, MUL_SS, 0), 64'h0001_0000_0000_0002,
            32'h3, ALL, 5'b00000, 5'b01110);
        run("ior", mk(OP_IOR, 0, 3'b000, MUL_SS, 0), 64'hF000_000F_0000_0000,
            32'hF00F, ALL, 5'b00100, 5'h1F);
        run("xor", mk(OP_XOR, 0, 3'b000, MUL_SS, 0), 64'hFFFF_FFFF_0000_0000,
            32'h0, ALL, 5'b01000, 5'h1F);
        run("shl", mk(OP_SHL, 0, 3'b000, MUL_SS, 0), 64'h8001_0000_0000_0000,
            32'h2, ALL, 5'b10000, 5'h1F);
        run("lsr_byte", mk(OP_LSR, 1, 3'b000, MUL_SS, 0), 64'h1281_0000_0000_0000,
            32'h40, ALL, 5'b10000, 5'h1F);
        run("asr", mk(OP_ASR, 0, 3'b000, MUL_SS, 0), 64'h8002_0000_0000_0000,
            32'hC001, ALL, 5'b00100, 5'h1F);
        run("mov_mem", mk(OP_MOV, 0, 3'b101, MUL_SS, 0), 64'h1234_0000_0000_0000,
            32'h0, ALL, 5'b01000, 5'h1F);
        conclude();
    end

    // ==========================================
    // watchdog, about ten times the expected run
    initial begin
        repeat (1500) @(posedge ref_clk);
        failures++;
        conclude();
    end
endmodule
